// ===== hdl/tsa_pkg.sv
/*
  Constants shared by the temperature sensor alert core: register pointer codes,
  configuration bit positions, reset values and conversion timing.
  Assumes a single 25 MHz core clock.
*/
package tsa_pkg;
  // Pointer codes
  localparam logic [2:0] PTR_TEMP    = 3'h0;
  localparam logic [2:0] PTR_CONFIG  = 3'h1;
  localparam logic [2:0] PTR_HYST    = 3'h2;
  localparam logic [2:0] PTR_OTEMP   = 3'h3;
  localparam logic [2:0] PTR_ONESHOT = 3'h4;

  // Configuration bit positions
  localparam int CFG_SHUTDOWN = 0;
  localparam int CFG_INT_MODE = 1;
  localparam int CFG_POLARITY = 2;
  localparam int CFG_FQ_LO    = 3;
  localparam int CFG_FQ_HI    = 4;
  localparam int CFG_ONESHOT  = 5;

  // Reset values and fixed read fields
  localparam logic [7:0]  PTR_RESET    = 8'h00;
  localparam logic [7:0]  CONFIG_RESET = 8'h00;
  localparam logic [11:0] TEMP_RESET   = 12'h000;
  localparam logic [11:0] HYST_RESET   = 12'h4b0;
  localparam logic [11:0] OTEMP_RESET  = 12'h500;
  localparam logic [3:0]  LOW_NIBBLE   = 4'h0;
  localparam logic [7:0]  ONESHOT_READ = 8'h00;

  // Fault queue depth per encoding
  localparam logic [2:0] FQ_DEPTH_0 = 3'h1;
  localparam logic [2:0] FQ_DEPTH_1 = 3'h2;
  localparam logic [2:0] FQ_DEPTH_2 = 3'h4;
  localparam logic [2:0] FQ_DEPTH_3 = 3'h6;

  // Timing
  localparam int CLK_HZ             = 25_000_000;
  localparam int CONV_PERIOD_MS     = 80;
  localparam int CONV_PERIOD_CYCLES = (CLK_HZ / 1000) * CONV_PERIOD_MS;
  localparam int PERIOD_W           = 21;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } tsa_state_e;
endpackage

// ===== hdl/tsa_core.sv
/*
  Digital core of a temperature sensor: conversion scheduling, register file
  behind a byte-level register port, fault queue and open-drain alert output.
  Assumes a serial-bus slave front end that delivers pointer and data bytes as
  one-cycle strobes, and an external converter that answers a start pulse with a
  done pulse and a 12-bit result.
*/
// How it works
// - In normal mode a new conversion starts every 80 ms.
// - Each finished conversion updates the result register and is compared with the limit.
// - Reads during a conversion return the old result and never disturb it.
// - Shutdown bit 0 stops conversions, keeps the last result, register port stays live.
// - A one-shot write while shut down runs one conversion and compare, then stops.
// - Config bit 5 selects one-shot mode, powered down until triggered.
// - The one-shot write itself triggers; its data is dropped and never stored.
// - Comparator mode clears the alert itself once temperature drops below hysteresis.
// - Interrupt mode holds the alert until a host read and temperature below hysteresis.
// - Alert active level is programmable high or low.
// - Temperature, limit and hysteresis are 16-bit left-justified 12-bit two's complement.
// - The low four bits of temperature-format registers read as zero.
// - Config bits 4:3 set consecutive faults needed before alert, up to six.
// - Write-only 8-bit pointer, low three bits select register, resets to zero.
// - Pointer codes 0..4 select result, config, hysteresis, limit, one-shot.
// - Result is read-only, others read/write; 8-bit and 16-bit widths as listed.
// - Fault queue codes 00,01,10,11 need 1,2,4,6 faults; reset 00.
// - Config bit 1 zero is comparator mode, one is interrupt mode.
// - Config bit 2 zero gives active low alert, one gives active high.
module tsa_core #(
  parameter int PERIOD_CYCLES = tsa_pkg::CONV_PERIOD_CYCLES
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Register port from the serial front end
  input  wire logic       txn_start,
  input  wire logic       ptr_wr,
  input  wire logic [7:0] ptr_wdata,
  input  wire logic       dat_wr,
  input  wire logic [7:0] dat_wdata,
  input  wire logic       rd_req,
  input  wire logic       rd_done,
  output logic      [7:0] rd_data,
  // Converter
  output logic            adc_start,
  output logic            adc_power,
  input  wire logic       adc_done,
  input  wire logic [11:0] adc_result,
  // Alert pin, open drain
  input  wire logic       overtemp_alert_in,
  output logic            overtemp_alert_out,
  output logic            overtemp_alert_oe
);

  typedef struct packed {
    logic [7:0]           ptr;
    logic [7:0]           cfg;
    logic [11:0]          hyst;
    logic [11:0]          otemp;
    logic [11:0]          temp;
    logic                 byte_idx;
    logic [7:0]           wr_msb;
    logic [7:0]           rd_lsb;
    logic [7:0]           rd_data;
    tsa_pkg::tsa_state_e  state;
    logic [tsa_pkg::PERIOD_W-1:0] period_cnt;
    logic                 oneshot_pend;
    logic                 adc_start;
    logic [2:0]           fault_cnt;
    logic                 active;
    logic                 acked;
    logic                 alert_oe;
    logic                 conv_on;
  } tsa_regs_s;

  tsa_regs_s q;
  tsa_regs_s d;

  logic [2:0]  sel;
  logic        normal_run;
  logic        fault;
  logic        below_hyst;
  logic [2:0]  fq_depth;
  logic [2:0]  fault_next;
  logic [15:0] rd_word;

  // Counter is sized for the full period; the top bits of the int are cut on purpose
  localparam logic [31:0]                  PERIOD_FULL   = 32'(PERIOD_CYCLES - 1);
  localparam logic [tsa_pkg::PERIOD_W-1:0] PERIOD_RELOAD = PERIOD_FULL[tsa_pkg::PERIOD_W-1:0];

  // The open-drain pin cannot read back a useful level for this core
  logic unused_pin;
  assign unused_pin = overtemp_alert_in;

  always_comb begin
    d          = q;
    sel        = q.ptr[2:0];
    normal_run = !q.cfg[tsa_pkg::CFG_SHUTDOWN] && !q.cfg[tsa_pkg::CFG_ONESHOT];
    fault      = $signed(adc_result) >= $signed(q.otemp);
    below_hyst = $signed(adc_result) < $signed(q.hyst);
    d.adc_start = 1'b0;

    case (q.cfg[tsa_pkg::CFG_FQ_HI:tsa_pkg::CFG_FQ_LO])
      2'b00:   fq_depth = tsa_pkg::FQ_DEPTH_0;
      2'b01:   fq_depth = tsa_pkg::FQ_DEPTH_1;
      2'b10:   fq_depth = tsa_pkg::FQ_DEPTH_2;
      default: fq_depth = tsa_pkg::FQ_DEPTH_3;
    endcase

    // Pointer select for reads; low nibble forced to zero
    if (sel == tsa_pkg::PTR_TEMP) begin
      rd_word = {q.temp, tsa_pkg::LOW_NIBBLE};
    end else if (sel == tsa_pkg::PTR_CONFIG) begin
      rd_word = {q.cfg, 8'h00};
    end else if (sel == tsa_pkg::PTR_HYST) begin
      rd_word = {q.hyst, tsa_pkg::LOW_NIBBLE};
    end else if (sel == tsa_pkg::PTR_OTEMP) begin
      rd_word = {q.otemp, tsa_pkg::LOW_NIBBLE};
    end else begin
      rd_word = {tsa_pkg::ONESHOT_READ, 8'h00};
    end

    // Register port
    if (txn_start) begin
      d.byte_idx = 1'b0;
    end
    if (ptr_wr) begin
      d.ptr      = ptr_wdata;
      d.byte_idx = 1'b0;
    end else if (dat_wr) begin
      if (sel == tsa_pkg::PTR_CONFIG) begin
        d.cfg = dat_wdata;
      end else if (sel == tsa_pkg::PTR_HYST || sel == tsa_pkg::PTR_OTEMP) begin
        // MSB first; the pair commits on the second byte
        if (!q.byte_idx) begin
          d.wr_msb   = dat_wdata;
          d.byte_idx = 1'b1;
        end else begin
          if (sel == tsa_pkg::PTR_HYST) begin
            d.hyst = {q.wr_msb, dat_wdata[7:4]};
          end else begin
            d.otemp = {q.wr_msb, dat_wdata[7:4]};
          end
          d.byte_idx = 1'b0;
        end
      end else if (sel == tsa_pkg::PTR_ONESHOT) begin
        // Only the strobe matters, the byte is dropped
        if (!normal_run) begin
          d.oneshot_pend = 1'b1;
        end
      end
    end else if (rd_req) begin
      // A snapshot on the first byte keeps both halves of one result together
      if (sel == tsa_pkg::PTR_CONFIG || sel == tsa_pkg::PTR_ONESHOT) begin
        d.rd_data = rd_word[15:8];
      end else if (!q.byte_idx) begin
        d.rd_data  = rd_word[15:8];
        d.rd_lsb   = rd_word[7:0];
        d.byte_idx = 1'b1;
      end else begin
        d.rd_data  = q.rd_lsb;
        d.byte_idx = 1'b0;
      end
    end

    // Conversion period runs only in normal mode
    if (normal_run) begin
      if (q.period_cnt == '0) begin
        d.period_cnt = PERIOD_RELOAD;
      end else begin
        d.period_cnt = q.period_cnt - 1'b1;
      end
    end else begin
      d.period_cnt = '0;
    end

    case (q.state)
      tsa_pkg::ST_IDLE: begin
        if ((normal_run && q.period_cnt == '0) || q.oneshot_pend) begin
          d.adc_start    = 1'b1;
          d.oneshot_pend = 1'b0;
          d.state        = tsa_pkg::ST_CONV;
        end
      end
      tsa_pkg::ST_CONV: begin
        // Reads keep seeing the old result until this point
        if (adc_done) begin
          d.temp  = adc_result;
          d.state = tsa_pkg::ST_IDLE;
        end
      end
      default: d.state = tsa_pkg::ST_IDLE;
    endcase

    // Fault queue and alert state
    fault_next = fault ? ((q.fault_cnt == fq_depth) ? q.fault_cnt : q.fault_cnt + 3'h1) : 3'h0;
    if (rd_done && q.active) begin
      d.acked = 1'b1;
    end
    if (q.state == tsa_pkg::ST_CONV && adc_done) begin
      d.fault_cnt = fault_next;
      if (fault && fault_next == fq_depth) begin
        d.active = 1'b1;
        d.acked  = 1'b0;
      end else if (below_hyst && q.active) begin
        if (!q.cfg[tsa_pkg::CFG_INT_MODE]) begin
          d.active = 1'b0;
        end else if (q.acked || (rd_done && q.active)) begin
          d.active = 1'b0;
          d.acked  = 1'b0;
        end
      end
    end

    // Open drain pulls low when the asserted level is low
    d.alert_oe = q.cfg[tsa_pkg::CFG_POLARITY] ? !d.active : d.active;
    // Power flag kept in its own flop so the output needs no decode
    d.conv_on  = d.state == tsa_pkg::ST_CONV;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      q              <= '0;
      q.ptr          <= tsa_pkg::PTR_RESET;
      q.cfg          <= tsa_pkg::CONFIG_RESET;
      q.hyst         <= tsa_pkg::HYST_RESET;
      q.otemp        <= tsa_pkg::OTEMP_RESET;
      q.temp         <= tsa_pkg::TEMP_RESET;
      q.state        <= tsa_pkg::ST_IDLE;
    end else begin
      q <= d;
    end
  end

  assign rd_data            = q.rd_data;
  assign adc_start          = q.adc_start;
  assign adc_power          = q.conv_on;
  assign overtemp_alert_out = 1'b0;
  assign overtemp_alert_oe  = q.alert_oe;

endmodule

// ===== verification/tsa_adc_model.sv
/*
  Converter stand-in for the alert core: answers each start pulse with a done
  pulse and the programmed code after lat+1 cycles.
  Assumes the bench sets value and lat before the start pulse.
*/
module tsa_adc_model (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Control from core and bench
  input  wire logic        adc_start,
  input  wire logic [3:0]  lat,
  input  wire logic [11:0] value,
  // Answer
  output logic             adc_done = 1'b0,
  output logic      [11:0] adc_result = 12'h000
);
  int cnt = 0;

  always @(posedge core_clk) begin
    adc_done <= 1'b0;
    // Result only valid with done; otherwise a toggling pattern
    adc_result <= ~adc_result;
    if (rst) begin
      cnt <= 0;
    end else if (adc_start) begin
      cnt <= int'(lat) + 1;
    end else if (cnt == 1) begin
      adc_done <= 1'b1;
      adc_result <= value;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// ===== verification/tsa_core_monitor.sv
/*
  Port checker for tsa_core: conversion handshake, read hold, alert pin.
  Bound to every tsa_core instance; sees only its ports.
*/
module tsa_core_monitor #(
  parameter int PERIOD_CYCLES = 50
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Register port
  input  wire logic       dat_wr,
  input  wire logic       rd_req,
  input  wire logic [7:0] rd_data,
  // Converter and alert
  input  wire logic       adc_start,
  input  wire logic       adc_power,
  input  wire logic       adc_done,
  input  wire logic       overtemp_alert_out,
  input  wire logic       overtemp_alert_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence conv_end_s;
    adc_power && adc_done;
  endsequence

  start_power_a: assert property (adc_start |=> adc_power)
    else $error("power low after start");
  start_gap_a: assert property (adc_start |=> !adc_start [*3])
    else $error("start pulses too close");
  power_cause_a: assert property ($rose(adc_power) |-> adc_start || $past(adc_start))
    else $error("power rose without start");
  conv_hold_a: assert property (adc_power && !adc_done |=> adc_power)
    else $error("conversion dropped early");
  conv_end_a: assert property (conv_end_s |=> !adc_power)
    else $error("power held after done");
  read_hold_a: assert property (!rd_req |=> $stable(rd_data))
    else $error("read data moved without request");
  pin_low_a: assert property (overtemp_alert_out == 1'b0)
    else $error("alert pin driven high");
  alert_cause_a: assert property ($changed(overtemp_alert_oe) |->
      $past(adc_done) || $past(dat_wr) || $past(dat_wr, 2))
    else $error("alert moved without conversion");
endmodule

bind tsa_core tsa_core_monitor #(.PERIOD_CYCLES(PERIOD_CYCLES)) tsa_core_monitor_i (.*);

// ===== verification/tsa_core_tb.sv
/*
  Self-checking bench for tsa_core: registers, conversions, fault queue, alert.
  Assumes the converter model and a short conversion period.
*/
module tsa_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PER = 50;
  logic        core_clk = 0, rst = 1, txn_start = 0, ptr_wr = 0, dat_wr = 0, rd_req = 0, rd_done = 0;
  logic [7:0]  ptr_wdata = 0, dat_wdata = 0, rd_data;
  logic        adc_start, adc_power, adc_done, overtemp_alert_out, overtemp_alert_oe;
  logic [11:0] adc_result, tval = 0;
  logic [15:0] last_rd = 0;
  logic [3:0]  lat = 4'h2;
  logic [31:0] seed = 32'h5fb3_0cdd;
  int          num_errors = 0, total_checks = 0, nstart = 0, cyc = 0, n0, i;

  tsa_core #(.PERIOD_CYCLES(PER)) tsa_core_i (.core_clk(core_clk), .rst(rst), .txn_start(txn_start),
    .ptr_wr(ptr_wr), .ptr_wdata(ptr_wdata), .dat_wr(dat_wr), .dat_wdata(dat_wdata), .rd_req(rd_req),
    .rd_done(rd_done), .rd_data(rd_data), .adc_start(adc_start), .adc_power(adc_power),
    .adc_done(adc_done), .adc_result(adc_result), .overtemp_alert_in(!overtemp_alert_oe),
    .overtemp_alert_out(overtemp_alert_out), .overtemp_alert_oe(overtemp_alert_oe));
  tsa_adc_model tsa_adc_model_i (.core_clk(core_clk), .rst(rst), .adc_start(adc_start), .lat(lat),
    .value(tval), .adc_done(adc_done), .adc_result(adc_result));

  always #20 core_clk = ~core_clk;

  function automatic logic [31:0] nx(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int depth(int f);
    return f == 3 ? 6 : 1 << f;
  endfunction
  // Whole degrees from a left-justified result word, as the host works it out
  function automatic int to_deg(logic [15:0] w);
    return (w[15] ? int'(w[15:4]) - 4096 : int'(w[15:4])) / 16;
  endfunction

  task test_done;
    if (num_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task ck(string n, logic [15:0] e, logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      num_errors++;
    end
  endtask
  task wr(logic [2:0] p, int n, logic [15:0] v);
    ptr_wr = 1;
    ptr_wdata = {5'h0, p};
    @(negedge core_clk);
    ptr_wr = 0;
    dat_wr = 1;
    dat_wdata = n == 2 ? v[15:8] : v[7:0];
    @(negedge core_clk);
    if (n == 2) begin
      dat_wdata = v[7:0];
      @(negedge core_clk);
    end
    dat_wr = 0;
  endtask
  // Every read ends with a completed-read pulse, as a real host would
  task rd(logic [2:0] p, int n, logic [15:0] e);
    logic [15:0] s;
    txn_start = 1;
    ptr_wr = 1;
    ptr_wdata = {5'h0, p};
    @(negedge core_clk);
    txn_start = 0;
    ptr_wr = 0;
    rd_req = 1;
    @(negedge core_clk);
    s = {8'h0, rd_data};
    if (n == 2) begin
      @(negedge core_clk);
      s = {s[7:0], rd_data};
    end
    rd_req = 0;
    rd_done = 1;
    @(negedge core_clk);
    rd_done = 0;
    last_rd = s;
    ck("read", e, s);
  endtask
  task conv(logic [11:0] v);
    seed = nx(seed);
    tval = v;
    lat = 4'h2 + {1'b0, seed[2:0]};
    n0 = nstart;
    wr(3'h4, 1, seed[15:0]);
    for (i = 0; i < 40 && !(adc_done && adc_power); i++) @(negedge core_clk);
    repeat (3) @(negedge core_clk);
    ck("starts", 16'h1, 16'(nstart - n0));
  endtask
  task idle;
    repeat (10) @(negedge core_clk);
    n0 = nstart;
    repeat (2 * PER) @(negedge core_clk);
    ck("idle", 16'h0, 16'(nstart - n0));
  endtask

  always @(posedge core_clk) begin
    cyc++;
    nstart += int'(adc_start === 1'b1);
    if (cyc == 8000) begin
      num_errors++;
      test_done();
    end
  end

  initial begin
    repeat (20) @(negedge core_clk);
    rst = 0;
    @(negedge core_clk);
    rd(3'h1, 1, 16'h0000);
    rd(3'h2, 2, 16'h4b00);
    rd(3'h3, 2, 16'h5000);
    seed = nx(seed);
    tval = {4'h0, seed[7:0]};
    for (i = 0; i < 200 && !adc_start; i++) @(negedge core_clk);
    n0 = cyc;
    @(negedge core_clk);
    for (i = 0; i < 200 && !adc_start; i++) @(negedge core_clk);
    ck("period", 16'(PER), 16'(cyc - n0));
    repeat (12) @(negedge core_clk);
    rd(3'h0, 2, {tval, 4'h0});
    wr(3'h0, 2, 16'hffff);
    rd(3'h0, 2, {tval, 4'h0});
    wr(3'h3, 2, {12'h320, seed[11:8]});
    wr(3'h2, 2, {12'h280, seed[15:12]});
    rd(3'h3, 2, 16'h3200);
    rd(3'h2, 2, 16'h2800);
    wr(3'h1, 1, 16'h0001);
    idle();
    for (int f = 0; f < 4; f++) begin
      wr(3'h1, 1, {11'h0, f[1:0], 3'b001});
      conv(12'h100);
      for (int k = 1; k <= depth(f); k++) begin
        seed = nx(seed);
        conv(12'h320 + {4'h0, seed[7:0]});
        ck("queue", 16'(k == depth(f)), {15'h0, overtemp_alert_oe});
      end
    end
    wr(3'h1, 1, 16'h0001);
    conv(12'h2c0);
    ck("hyst", 16'h1, {15'h0, overtemp_alert_oe});
    conv(12'h27f);
    ck("clear", 16'h0, {15'h0, overtemp_alert_oe});
    wr(3'h1, 1, 16'h0005);
    conv(12'h320);
    ck("pol", 16'h0, {15'h0, overtemp_alert_oe});
    conv(12'h100);
    ck("pol", 16'h1, {15'h0, overtemp_alert_oe});
    wr(3'h1, 1, 16'h0003);
    conv(12'h7ff);
    ck("int", 16'h1, {15'h0, overtemp_alert_oe});
    conv(12'h100);
    ck("int", 16'h1, {15'h0, overtemp_alert_oe});
    rd(3'h0, 1, 16'h0010);
    conv(12'hc90);
    ck("int", 16'h0, {15'h0, overtemp_alert_oe});
    rd(3'h0, 2, 16'hc900);
    ck("degrees", 16'hffc9, 16'(to_deg(last_rd)));
    wr(3'h1, 1, 16'h0020);
    idle();
    conv(12'h190);
    rd(3'h4, 1, 16'h0000);
    rd(3'h0, 2, 16'h1900);
    ck("degrees", 16'h0019, 16'(to_deg(last_rd)));
    test_done();
  end
endmodule
